/* File: hport_pkg.sv */
// Purpose: shared constants for the host port and output gate
// Assumes: 100 MHz clock
// Notes: irq queue depth and register map are local choices
package hport_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 11;
	localparam int QUEUE_DEPTH = 16;
	localparam int QPTR_W = 4;
	localparam int CTRL_ODE_BIT = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [10:0] ADDR_CTRL = 11'h000;
	localparam logic [10:0] ADDR_IRQ_QUEUE = 11'h001;
	localparam logic [7:0] QUEUE_EMPTY_CODE = 8'hff;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACK = 2'b01,
		ST_WAIT = 2'b10
	} port_state_t;
endpackage

/* File: irq_queue.sv */
// Purpose: queue of pending interrupt entries
// Assumes: one push and one pop port, single clock
// Notes: a full queue drops new entries unless a pop happens in the same cycle
`timescale 1ns/10ps
module irq_queue
	import hport_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH,
	parameter int PTR_W = QPTR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// push side
	input wire logic push,
	input wire logic [DATA_W-1:0] push_data,
	// pop side
	input wire logic pop,
	output logic [DATA_W-1:0] head,
	output logic not_empty
);
	typedef struct packed {
		logic [DEPTH-1:0][DATA_W-1:0] mem;
		logic [PTR_W-1:0] rd;
		logic [PTR_W-1:0] wr;
		logic [PTR_W:0] count;
	} q_state_t;
	q_state_t q, next_q;
	logic do_push, do_pop;
	always_comb begin
		next_q = q;
		do_pop = pop && (q.count != '0);
		do_push = push && (q.count != (PTR_W+1)'(DEPTH) || do_pop);
		if (do_push) begin
			next_q.mem[q.wr] = push_data;
			next_q.wr = q.wr + 1'b1;
		end
		if (do_pop) begin
			next_q.rd = q.rd + 1'b1;
		end
		next_q.count = q.count + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
	assign head = q.mem[q.rd];
	assign not_empty = (q.count != '0);
endmodule

/* File: host_port_irq_output_gate.sv */
// Purpose: 8-bit non-multiplexed host port, irq queue and serial output gate
// Assumes: host pins synchronous to clk
// Notes: open-drain pins appear as output plus enable
`timescale 1ns/10ps
module host_port_irq_output_gate
	import hport_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// host bus
	input wire logic select_n,
	input wire logic access_strobe_n,
	input wire logic read_not_write,
	input wire logic [ADDR_W-1:0] host_address_bus,
	input wire logic [DATA_W-1:0] host_data_in,
	output logic [DATA_W-1:0] host_data_out,
	output logic host_data_oe,
	output logic transfer_ack_n_out,
	output logic transfer_ack_oe,
	// interrupt
	input wire logic irq_event,
	input wire logic [DATA_W-1:0] irq_entry,
	output logic irq_n_out,
	output logic irq_oe,
	// serial output gate
	input wire logic serial_output_enable,
	output logic serial_outputs_oe,
	output logic [DATA_W-1:0] ctrl_value
);
	typedef struct packed {
		port_state_t st;
		logic [DATA_W-1:0] ctrl;
		logic [DATA_W-1:0] rdata;
		logic rd;
	} port_t;
	port_t s, next_s;
	logic access, pop, q_ne;
	logic [DATA_W-1:0] q_head;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic is_ctrl_addr(input logic [ADDR_W-1:0] a);
		return a == ADDR_CTRL;
	endfunction
	function automatic logic is_queue_addr(input logic [ADDR_W-1:0] a);
		return a == ADDR_IRQ_QUEUE;
	endfunction

	// ----------------------------------------
	// interrupt queue
	// ----------------------------------------
	irq_queue #(.DEPTH(DEPTH), .PTR_W(QPTR_W)) u_queue (
		.clk(clk),
		.nrst(nrst),
		.push(irq_event),
		.push_data(irq_entry),
		.pop(pop),
		.head(q_head),
		.not_empty(q_ne)
	);

	// ----------------------------------------
	// access sequencer
	// ----------------------------------------
	assign access = !select_n && !access_strobe_n;
	always_comb begin
		next_s = s;
		pop = 1'b0;
		unique case (s.st)
			ST_IDLE: begin
				if (access) begin
					next_s.st = ST_ACK;
					next_s.rd = read_not_write;
					if (read_not_write) begin
						unique case (host_address_bus)
							ADDR_CTRL: next_s.rdata = s.ctrl;
							ADDR_IRQ_QUEUE: begin
								next_s.rdata = q_ne ? q_head : QUEUE_EMPTY_CODE;
								pop = q_ne;
							end
							default: next_s.rdata = '0;
						endcase
					end else if (is_ctrl_addr(host_address_bus)) begin
						next_s.ctrl = host_data_in;
					end
				end
			end
			ST_ACK: begin
				if (!access) begin
					next_s.st = ST_IDLE;
				end
			end
			default: next_s.st = ST_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s <= '{st: ST_IDLE, ctrl: CTRL_RESET, rdata: '0, rd: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	assign host_data_out = s.rdata;
	assign host_data_oe = (s.st == ST_ACK) && s.rd && access;
	assign transfer_ack_n_out = 1'b0;
	assign transfer_ack_oe = (s.st == ST_ACK) && access;
	assign irq_n_out = 1'b0;
	assign irq_oe = q_ne;
	assign serial_outputs_oe = serial_output_enable && s.ctrl[CTRL_ODE_BIT];
	assign ctrl_value = s.ctrl;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_access_start;
		(s.st == ST_IDLE) && access;
	endsequence
	property p_ack_follows;
		@(posedge clk) disable iff (!nrst) s_access_start |=> transfer_ack_oe || !access;
	endproperty
	a_ack_follows: assert property (p_ack_follows) else $error("ack missing");
	property p_no_ack_unselected;
		@(posedge clk) disable iff (!nrst) select_n |-> !transfer_ack_oe;
	endproperty
	a_no_ack_unselected: assert property (p_no_ack_unselected) else $error("ack without select");
	sequence s_ack_drop;
		(s.st == ST_ACK) && !access;
	endsequence
	property p_ack_release;
		@(posedge clk) disable iff (!nrst) s_ack_drop |=> (s.st == ST_IDLE) && !transfer_ack_oe;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("ack held");
	property p_gate;
		@(posedge clk) disable iff (!nrst)
			serial_outputs_oe == (serial_output_enable && ctrl_value[CTRL_ODE_BIT]);
	endproperty
	a_gate: assert property (p_gate) else $error("gate wrong");
	property p_gate_off;
		@(posedge clk) disable iff (!nrst) !serial_output_enable |-> !serial_outputs_oe;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("outputs not released");
	property p_irq_set;
		@(posedge clk) disable iff (!nrst) irq_event |=> irq_oe;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq not raised");
	property p_irq_hold;
		@(posedge clk) disable iff (!nrst) irq_oe && !pop |=> irq_oe;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
	property p_read_drive;
		@(posedge clk) disable iff (!nrst) host_data_oe |-> read_not_write && !select_n;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("bad drive");

	// ----------------------------------------
	// checks: register access
	// ----------------------------------------
	sequence s_ctrl_write;
		(s.st == ST_IDLE) && access && !read_not_write && is_ctrl_addr(host_address_bus);
	endsequence
	property p_write_lands;
		@(posedge clk) disable iff (!nrst) s_ctrl_write |=> ctrl_value == $past(host_data_in);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write lost");
	property p_stray_write;
		@(posedge clk) disable iff (!nrst) select_n |=> ctrl_value == $past(ctrl_value);
	endproperty
	a_stray_write: assert property (p_stray_write) else $error("write without select");
	sequence s_ctrl_read;
		(s.st == ST_IDLE) && access && read_not_write && is_ctrl_addr(host_address_bus);
	endsequence
	property p_ctrl_readback;
		@(posedge clk) disable iff (!nrst) s_ctrl_read |=> host_data_out == ctrl_value;
	endproperty
	a_ctrl_readback: assert property (p_ctrl_readback) else $error("read data wrong");
	sequence s_empty_read;
		(s.st == ST_IDLE) && access && read_not_write && is_queue_addr(host_address_bus) && !q_ne;
	endsequence
	property p_empty_code;
		@(posedge clk) disable iff (!nrst) s_empty_read |=> host_data_out == QUEUE_EMPTY_CODE;
	endproperty
	a_empty_code: assert property (p_empty_code) else $error("empty queue code wrong");
	sequence s_queue_read;
		(s.st == ST_IDLE) && access && read_not_write && is_queue_addr(host_address_bus) && q_ne;
	endsequence
	property p_queue_pop;
		@(posedge clk) disable iff (!nrst) s_queue_read |-> pop;
	endproperty
	a_queue_pop: assert property (p_queue_pop) else $error("queue read without pop");
	property p_single_pop;
		@(posedge clk) disable iff (!nrst) pop |-> is_queue_addr(host_address_bus) ##1 !pop;
	endproperty
	a_single_pop: assert property (p_single_pop) else $error("more than one entry per access");
	property p_write_quiet;
		@(posedge clk) disable iff (!nrst) (s.st == ST_IDLE) && access && !read_not_write |=> !host_data_oe;
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("data driven on write");

	// ----------------------------------------
	// checks: irq and gate
	// ----------------------------------------
	property p_irq_quiet;
		@(posedge clk) disable iff (!nrst) !irq_oe && !irq_event |=> !irq_oe;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq without event");
	property p_gate_ctrl_off;
		@(posedge clk) disable iff (!nrst) !ctrl_value[CTRL_ODE_BIT] |-> !serial_outputs_oe;
	endproperty
	a_gate_ctrl_off: assert property (p_gate_ctrl_off) else $error("outputs on with bit low");
endmodule

/* File: host_model.sv */
// Purpose: host processor on the parallel port
// Assumes: design samples at rising clk
// Notes: released lines show inverted data
`timescale 1ns/10ps
module host_model
	import hport_pkg::*;
(
	// bus
	input wire logic clk,
	input wire logic ack_oe,
	input wire logic [DATA_W-1:0] rdata,
	output logic select_n,
	output logic strobe_n,
	output logic rnw,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] wdata
);
	task automatic bus_idle();
		select_n = 1'b1;
		strobe_n = 1'b1;
		rnw = 1'b1;
		addr = '0;
		wdata = '0;
	endtask
	task automatic xfer(input logic sel, input logic rd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic ok);
		ok = 1'b0;
		q = '0;
		@(negedge clk);
		select_n = ~sel;
		strobe_n = 1'b0;
		rnw = rd;
		addr = a;
		wdata = d;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge clk);
			ok = (ack_oe === 1'b1);
			q = rdata;
		end
		@(negedge clk);
		select_n = 1'b1;
		strobe_n = 1'b1;
		wdata = ~wdata;
		addr = ~addr;
	endtask
endmodule

/* File: testbench.sv */
// Purpose: random and corner tests of the host port
// Assumes: default queue depth
// Notes: inputs change at falling clk
`timescale 1ns/10ps
module testbench
	import hport_pkg::*;
;
	logic clk, nrst, sel_n, stb_n, rnw, dat_oe, ack_oe, irq_oe, ev, soe, s_oe, ok;
	logic ack_n, irq_n;
	logic [ADDR_W-1:0] a, far_addr;
	logic [7:0] wd, rd, irq_entry, ctrl, q, v;
	logic [15:0] lfsr;
	logic [7:0] exp_q[$];
	int fails = 0;
	int cmp_count = 0;
	host_port_irq_output_gate host_port_irq_output_gate_inst(.clk(clk), .nrst(nrst),
		.select_n(sel_n), .access_strobe_n(stb_n), .read_not_write(rnw),
		.host_address_bus(a), .host_data_in(wd), .host_data_out(rd), .host_data_oe(dat_oe),
		.transfer_ack_n_out(ack_n), .transfer_ack_oe(ack_oe), .irq_event(ev),
		.irq_entry(irq_entry), .irq_n_out(irq_n), .irq_oe(irq_oe),
		.serial_output_enable(soe), .serial_outputs_oe(s_oe), .ctrl_value(ctrl));
	host_model host_model_inst(.clk(clk), .ack_oe(ack_oe && !ack_n), .rdata(dat_oe ? rd : 8'hzz),
		.select_n(sel_n), .strobe_n(stb_n), .rnw(rnw), .addr(a), .wdata(wd));
	//----------------
	// helpers
	//----------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		cmp_count++;
		if (got !== want) begin
			fails++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask
	task automatic chk_bit(input logic got, input logic want);
		cmp_count++;
		if (got !== want) begin
			fails++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask
	function automatic logic exp_gate(input logic pin, input logic [7:0] c);
		return pin & c[CTRL_ODE_BIT];
	endfunction
	task automatic push_events(input int n);
		for (int k = 0; k < n; k++) begin
			@(negedge clk);
			ev = 1'b1;
			lfsr = lfsr_next(lfsr);
			irq_entry = lfsr[7:0];
			if (exp_q.size() < QUEUE_DEPTH) exp_q.push_back(lfsr[7:0]);
		end
		@(negedge clk) ev = 1'b0;
		@(posedge clk) #1 chk_bit(irq_oe && !irq_n, 1'b1);
	endtask
	task automatic drain();
		while (exp_q.size() > 0) begin
			host_model_inst.xfer(1'b1, 1'b1, ADDR_IRQ_QUEUE, 8'h00, q, ok);
			chk(q, exp_q.pop_front());
			repeat (2) @(posedge clk);
			#1 chk_bit(irq_oe && !irq_n, exp_q.size() != 0);
		end
		host_model_inst.xfer(1'b1, 1'b1, ADDR_IRQ_QUEUE, 8'h00, q, ok);
		chk(q, QUEUE_EMPTY_CODE);
	endtask
	task automatic final_report();
		$display("fails=%0d cmp_count=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		final_report();
	end
	initial begin
		nrst = 1'b0;
		ev = 1'b0;
		irq_entry = 8'h00;
		soe = 1'b0;
		lfsr = 16'hd790;
		host_model_inst.bus_idle();
		repeat (5) @(posedge clk);
		@(negedge clk) nrst = 1'b1;
		for (int k = 0; k < 4; k++) begin
			v = k[1] ? 8'h40 : 8'hbf;
			host_model_inst.xfer(1'b1, 1'b0, ADDR_CTRL, v, q, ok);
			soe = k[0];
			#1;
			chk_bit(ok, 1'b1);
			chk_bit(ack_oe && !ack_n, 1'b0);
			chk_bit(s_oe, exp_gate(k[0], v));
			host_model_inst.xfer(1'b1, 1'b1, ADDR_CTRL, 8'h00, q, ok);
			chk_bit(ok, 1'b1);
			chk(q, v);
		end
		for (int k = 0; k < 8; k++) begin
			lfsr = lfsr_next(lfsr);
			v = lfsr[7:0];
			far_addr = {1'b1, lfsr[15:6]};
			host_model_inst.xfer(1'b1, 1'b0, ADDR_CTRL, v, q, ok);
			host_model_inst.xfer(1'b1, 1'b0, far_addr, ~v, q, ok);
			chk(ctrl, v);
			host_model_inst.xfer(1'b1, 1'b1, far_addr, 8'h00, q, ok);
			chk_bit(ok, 1'b1);
			chk(q, 8'h00);
			chk_bit(s_oe, exp_gate(soe, v));
		end
		host_model_inst.xfer(1'b0, 1'b0, ADDR_CTRL, ~v, q, ok);
		chk_bit(ok, 1'b0);
		chk(ctrl, v);
		$display("control test done");
		push_events(5);
		drain();
		$display("irq test done");
		push_events(QUEUE_DEPTH + 1);
		drain();
		$display("queue full test done");
		push_events(3);
		host_model_inst.xfer(1'b1, 1'b0, ADDR_CTRL, 8'h40, q, ok);
		@(negedge clk) nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		exp_q.delete();
		#1;
		chk(ctrl, CTRL_RESET);
		chk_bit(s_oe, 1'b0);
		chk_bit(irq_oe && !irq_n, 1'b0);
		drain();
		$display("reset test done");
		final_report();
	end
endmodule
